/* File: hdl/pll_holdover_control_status.sv */
// Holdover control and status registers of the PLL
// Summary of operation
// [RULE_01] Readback-disable bit set hides status register reads; clear (reset) allows them.
// [RULE_02] Comparator-enable turns on lock-detect comparator; clear means pin treated high.
// [RULE_03] Automatic mode with comparator uses pin voltage as previous-lock judgement.
// [RULE_04] Outside automatic holdover, comparator result drives monitor and status pins. Only ctrl.pin_monitor is driven; there is no status pin output.
// [RULE_05] Holdover active only when both enable bits set; reset clears both.
// [RULE_06] Software keeps automatic holdover off during VCO calibration.
// [RULE_07] External-holdover bit hands control to alignment pin; clear means automatic.
// [RULE_08] Status bit reads 1 after VCO calibration finished, else 0.
// [RULE_09] Status bit reads 1 while in holdover state, regardless of enables.
// [RULE_10] Status bit shows which reference currently feeds the PLL.
// [RULE_11] Reference bit reads 0 for first or differential, 1 for second.
// [RULE_12] Status reflects live state at read; writes to status register ignored.
//
// The plain strobed port was left to the implementer.
`include "pll_holdover_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pll_holdover_control_status (
  input wire logic clk,
  input wire logic rstn,
  input wire pll_holdover_pkg::reg_req_t req,
  output var logic [7:0] rdata,
  input wire pll_holdover_pkg::pll_state_t pll_in,
  output var pll_holdover_pkg::holdover_ctrl_t ctrl,
  output var logic irq
);
  import pll_holdover_pkg::*;

  // Pin-side inputs come from other domains; two flops before use
  pll_state_t sync1;
  pll_state_t sync2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pll_in;
      sync2 <= sync1;
    end
  end

  logic [7:0] control;
  logic [7:0] irq_status;
  logic [7:0] irq_enable;
  pll_state_t prev;

  wire wr_control = req.wr && (req.addr == `ADDR_HOLDOVER_CONTROL);
  wire wr_clear = req.wr && (req.addr == `ADDR_IRQ_CLEAR);
  wire wr_enable = req.wr && (req.addr == `ADDR_IRQ_ENABLE);

  wire readback_disable = control[`BIT_READBACK_DISABLE];
  wire comparator_enable = control[`BIT_COMPARATOR_ENABLE];
  wire external_holdover = control[`BIT_EXTERNAL_HOLDOVER];
  wire holdover_enable = control[`BIT_HOLDOVER_ENABLE_HI]
                       && control[`BIT_HOLDOVER_ENABLE_LO]; // [RULE_05]
  // Comparator off means the controller sees the pin as high
  wire lock_seen = comparator_enable ? sync2.lock_detect_comparator : 1'b1; // [RULE_02] [RULE_03]
  wire automatic_use = holdover_enable && !external_holdover; // [RULE_07]
  wire pin_monitor = !automatic_use && comparator_enable
                   && sync2.lock_detect_comparator; // [RULE_04]

  // Live status; bits outside this block read zero
  wire [7:0] status_word = {1'b0, sync2.cal_done, sync2.holdover_active,
                            sync2.second_ref_selected, 4'h0}; // [RULE_08] [RULE_09] [RULE_10] [RULE_11]

  wire [7:0] events = {5'h00,
                       sync2.second_ref_selected != prev.second_ref_selected,
                       sync2.holdover_active && !prev.holdover_active,
                       sync2.cal_done && !prev.cal_done};
  // Set wins over clear so no event is lost
  wire [7:0] next_irq_status = ((irq_status & ~(wr_clear ? req.wdata : 8'h00)) | events)
                             & `IRQ_MASK;

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      `ADDR_HOLDOVER_CONTROL: read_mux = control;
      `ADDR_READBACK_STATUS: read_mux = readback_disable ? 8'h00 : status_word; // [RULE_01] [RULE_12]
      `ADDR_IRQ_STATUS: read_mux = irq_status;
      `ADDR_IRQ_ENABLE: read_mux = irq_enable;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control <= `CONTROL_RESET;
      irq_enable <= `IRQ_RESET;
    end else begin
      if (wr_control) control <= req.wdata & `CONTROL_MASK; // [RULE_07]
      if (wr_enable) irq_enable <= req.wdata & `IRQ_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= `IRQ_RESET;
      prev <= '0;
      irq <= 1'b0;
      rdata <= 8'h00;
      ctrl <= '0;
    end else begin
      irq_status <= next_irq_status;
      prev <= sync2;
      irq <= |(next_irq_status & irq_enable);
      rdata <= req.rd ? read_mux(req.addr) : 8'h00;
      ctrl <= '{comparator_enable: comparator_enable, holdover_enable: holdover_enable,
                external_holdover: external_holdover, lock_for_automatic: lock_seen,
                pin_monitor: pin_monitor};
    end
  end

  property p_readback_hidden;
    @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ADDR_READBACK_STATUS && readback_disable) |=> rdata == 8'h00;
  endproperty
  a_readback_hidden: assert property (p_readback_hidden) else $error("status read not hidden"); // [RULE_01]

  property p_readback_live;
    @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ADDR_READBACK_STATUS && !readback_disable)
        |=> rdata[`BIT_CAL_DONE] == $past(sync2.cal_done);
  endproperty
  a_readback_live: assert property (p_readback_live) else $error("cal done readback wrong"); // [RULE_08]

  property p_holdover_bit;
    @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ADDR_READBACK_STATUS && !readback_disable)
        |=> rdata[`BIT_HOLDOVER_ACTIVE] == $past(sync2.holdover_active);
  endproperty
  a_holdover_bit: assert property (p_holdover_bit) else $error("holdover readback wrong"); // [RULE_09]

  property p_ref_bit;
    @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ADDR_READBACK_STATUS && !readback_disable)
        |=> rdata[`BIT_SECOND_REF] == $past(sync2.second_ref_selected);
  endproperty
  a_ref_bit: assert property (p_ref_bit) else $error("reference readback wrong"); // [RULE_10] [RULE_11]

  property p_enable_both;
    @(posedge clk) disable iff (!rstn)
      ##1 ctrl.holdover_enable == ($past(control[2]) && $past(control[0]));
  endproperty
  a_enable_both: assert property (p_enable_both) else $error("holdover enable wrong"); // [RULE_05]

  property p_comparator_off;
    @(posedge clk) disable iff (!rstn)
      !comparator_enable |=> ctrl.lock_for_automatic;
  endproperty
  a_comparator_off: assert property (p_comparator_off) else $error("pin not treated high"); // [RULE_02]

  property p_lock_follow;
    @(posedge clk) disable iff (!rstn)
      comparator_enable |=> ctrl.lock_for_automatic == $past(sync2.lock_detect_comparator);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock judgement wrong"); // [RULE_03]

  property p_monitor_auto;
    @(posedge clk) disable iff (!rstn)
      automatic_use |=> !ctrl.pin_monitor;
  endproperty
  a_monitor_auto: assert property (p_monitor_auto) else $error("monitor in automatic mode"); // [RULE_04]

  property p_status_write_ignored;
    @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `ADDR_READBACK_STATUS) |=> control == $past(control);
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("status write took"); // [RULE_12]

  property p_external;
    @(posedge clk) disable iff (!rstn)
      wr_control |=> ##1 ctrl.external_holdover == $past(req.wdata[`BIT_EXTERNAL_HOLDOVER], 2);
  endproperty
  a_external: assert property (p_external) else $error("external holdover wrong"); // [RULE_07]
endmodule : pll_holdover_control_status

`default_nettype wire

/* File: include/pll_holdover_consts.svh */
// Register offsets, field positions and reset values of the holdover control block
`ifndef PLL_HOLDOVER_CONSTS_SVH
`define PLL_HOLDOVER_CONSTS_SVH
`define ADDR_HOLDOVER_CONTROL 8'h1D
`define ADDR_READBACK_STATUS 8'h1F
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_CLEAR 8'h21
`define ADDR_IRQ_ENABLE 8'h22
`define BIT_READBACK_DISABLE 4
`define BIT_COMPARATOR_ENABLE 3
`define BIT_HOLDOVER_ENABLE_HI 2
`define BIT_EXTERNAL_HOLDOVER 1
`define BIT_HOLDOVER_ENABLE_LO 0
`define BIT_CAL_DONE 6
`define BIT_HOLDOVER_ACTIVE 5
`define BIT_SECOND_REF 4
`define CONTROL_RESET 8'h00
`define CONTROL_MASK 8'h1F
`define IRQ_RESET 8'h00
`define IRQ_MASK 8'h07
`define IRQ_CAL_DONE 0
`define IRQ_HOLDOVER_ENTER 1
`define IRQ_REF_CHANGE 2
`endif

/* File: include/pll_holdover_pkg.sv */
// Types shared by the holdover control block
package pll_holdover_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic cal_done;
    logic holdover_active;
    logic second_ref_selected;
    logic lock_detect_comparator;
    logic sync_pin;
  } pll_state_t;
  typedef struct packed {
    logic comparator_enable;
    logic holdover_enable;
    logic external_holdover;
    logic lock_for_automatic;
    logic pin_monitor;
  } holdover_ctrl_t;
endpackage : pll_holdover_pkg

/* File: test/pll_holdover_control_status_bench.sv */
// Self-checking bench of the holdover control block
`timescale 1ns/1ps
`default_nettype none
module pll_holdover_control_status_bench;
  import pll_holdover_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  reg_req_t req = '0;
  pll_state_t pll_in = '0;
  logic [7:0] rdata;
  holdover_ctrl_t ctrl;
  logic irq;
  logic rd_seen = 0;
  logic [7:0] q[$];
  logic [7:0] wd;
  logic [4:0] s;
  int bad_count = 0;
  int n_compared = 0;
  pll_holdover_control_status pll_holdover_control_status_i (.clk(clk), .rstn(rstn),
    .req(req), .rdata(rdata), .pll_in(pll_in), .ctrl(ctrl), .irq(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Gap cycle between strobes keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    q.push_back(e);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
  endtask : rd
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, q.pop_front());
    rd_seen <= req.rd;
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(60800));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({3'b000, ctrl}, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'h1F, 8'h00);
    // Comparator input held low, so comparator-on must show 0
    for (int i = 0; i < 32; i++) begin
      wd = {3'($urandom), 5'(i)};
      wr(8'h1D, wd);
      @(posedge clk);
      #1;
      chk(ctrl.holdover_enable, wd[2] & wd[0]);
      chk(ctrl.external_holdover, wd[1]);
      chk(ctrl.comparator_enable, wd[3]);
      chk(ctrl.lock_for_automatic, !wd[3]);
      rd(8'h1D, wd & 8'h1F);
    end
    wr(8'h1D, 8'h00);
    for (int i = 0; i < 8; i++) begin
      s = 5'($urandom);
      pll_in <= s;
      repeat (3) @(posedge clk);
      rd(8'h1F, {1'b0, s[4:2], 4'h0});
      wr(8'h1F, 8'hFF);
      rd(8'h1F, {1'b0, s[4:2], 4'h0});
    end
    pll_in <= 5'h1C;
    wr(8'h1D, 8'h10);
    rd(8'h1F, 8'h00);
    rd(8'h1D, 8'h10);
    rd(8'h55, 8'h00);
    // Lock-detect comparator input high for the monitor checks
    pll_in <= 5'h02;
    repeat (2) @(posedge clk);
    wr(8'h1D, 8'h08);
    @(posedge clk);
    #1;
    chk(ctrl.pin_monitor, 1'b1);
    chk(ctrl.lock_for_automatic, 1'b1);
    wr(8'h1D, 8'h0D);
    @(posedge clk);
    #1;
    chk(ctrl.pin_monitor, 1'b0);
    chk(ctrl.lock_for_automatic, 1'b1);
    wr(8'h1D, 8'h0F);
    @(posedge clk);
    #1;
    chk(ctrl.pin_monitor, 1'b1);
    chk(ctrl.external_holdover, 1'b1);
    wr(8'h1D, 8'h10);
    pll_in <= '0;
    wr(8'h22, 8'h01);
    wr(8'h21, 8'h07);
    rd(8'h20, 8'h00);
    // Calibration-done event raises irq; irq enable masks it and irq clear removes it
    pll_in.cal_done <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(irq, 8'h01);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h01);
    wr(8'h22, 8'h00);
    @(posedge clk);
    #1;
    chk(irq, 8'h00);
    wr(8'h22, 8'h01);
    @(posedge clk);
    #1;
    chk(irq, 8'h01);
    wr(8'h21, 8'h01);
    @(posedge clk);
    #1;
    chk(irq, 8'h00);
    rd(8'h20, 8'h00);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule : pll_holdover_control_status_bench
`default_nettype wire
